// File: common/ctr_cfg.svh
`ifndef CTR_CFG_SVH
`define CTR_CFG_SVH

// register offsets, compared with the bus address as it stands
`define CTR_IDX_OSC_CTRL 8'hDB
`define CTR_IDX_RST_STAT 8'hDC
`define CTR_IDX_CPU_CTRL 8'hDD
// standby oscillator control/status fields
`define CTR_BIT_IRQ_EN 7
`define CTR_BIT_ELAPSED 6
`define CTR_BIT_OSC_RUN 5
`define CTR_OSC_RESET 8'h00
// reset cause fields
`define CTR_BIT_CAUSE_PIN 0
`define CTR_BIT_CAUSE_POR 1
`define CTR_BIT_CAUSE_WDG 2
// cpu control fields
`define CTR_BIT_RETURN_FROM_INTERRUPT 0
`define CTR_BIT_IRQ_PEND 1
// dividers and counts
`define CTR_MACHINE_DIV 13
`define CTR_PERIPH_DIV 12
`define CTR_DIV_W 4
`define CTR_CHAIN_W 14
`define CTR_CHAIN_LAST 14'h3FFF
`define CTR_STAB_CYCLES 2048
`define CTR_STAB_W 12
`define CTR_RESET_VECTOR 12'hFFE
`define CTR_PHASE_W 3
`define CTR_PHASE_LAST_2 3'h1
`define CTR_PHASE_LAST_4 3'h3
`define CTR_PHASE_LAST_5 3'h4

`endif

// File: common/ctr_pkg.sv
package ctr_pkg;

  typedef enum logic [1:0] {
    CTR_ST_HOLD = 2'b00,
    CTR_ST_WAIT_OSC = 2'b01,
    CTR_ST_STAB = 2'b10,
    CTR_ST_RUN = 2'b11
  } ctr_state_t;

  typedef enum logic [1:0] {
    CTR_CTX_NORMAL = 2'b00,
    CTR_CTX_IRQ = 2'b01,
    CTR_CTX_NMI = 2'b10
  } ctr_ctx_t;

  typedef enum logic [1:0] {
    CTR_LEN_2 = 2'b00,
    CTR_LEN_4 = 2'b01,
    CTR_LEN_5 = 2'b10
  } ctr_ilen_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } ctr_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } ctr_wb_rsp_t;

  typedef struct packed {
    logic core_reset;
    logic stack_clear;
    logic [11:0] pc_load;
    logic pc_load_en;
    ctr_ctx_t ctx;
    logic service_pending;
  } ctr_cpu_ctl_t;

endpackage

// File: hw/ctr_clock_reset.sv
`timescale 1ns/100ps
`include "ctr_cfg.svh"

module ctr_clock_reset (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire ctr_pkg::ctr_wb_req_t wb_req_i,
  output ctr_pkg::ctr_wb_rsp_t wb_rsp_o,
  input wire logic reset_n_i,
  input wire logic por_i,
  input wire logic wdg_timeout_i,
  input wire logic osc_ready_i,
  input wire logic stop_mode_i,
  input wire logic standby_tick_i,
  input wire logic retire_i,
  input wire ctr_pkg::ctr_ilen_t ilen_i,
  output logic machine_tick_o,
  output logic periph_tick_o,
  output logic instr_done_o,
  output logic timebase_irq_o,
  output logic standby_osc_en_o,
  output logic display_clk_en_o,
  output logic internal_reset_o,
  output logic io_pullup_o,
  output logic main_osc_restart_o,
  output logic wdg_reload_o,
  output ctr_pkg::ctr_cpu_ctl_t cpu_ctl_o
);
  import ctr_pkg::*;

  function automatic logic [`CTR_DIV_W-1:0] wrap_inc(input logic [`CTR_DIV_W-1:0] v, input int unsigned m);
    wrap_inc = (v == `CTR_DIV_W'(m - 1)) ? '0 : v + `CTR_DIV_W'(1);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // clock dividers

  logic [`CTR_DIV_W-1:0] mdiv_reg;
  logic [`CTR_DIV_W-1:0] pdiv_reg;
  logic mtick_reg;
  logic ptick_reg;
  wire mdiv_wrap = (mdiv_reg == `CTR_DIV_W'(`CTR_MACHINE_DIV - 1));
  wire pdiv_wrap = (pdiv_reg == `CTR_DIV_W'(`CTR_PERIPH_DIV - 1));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mdiv_reg <= '0;
      pdiv_reg <= '0;
      mtick_reg <= 1'b0;
      ptick_reg <= 1'b0;
    end else begin
      mdiv_reg <= wrap_inc(mdiv_reg, `CTR_MACHINE_DIV);
      pdiv_reg <= wrap_inc(pdiv_reg, `CTR_PERIPH_DIV);
      mtick_reg <= mdiv_wrap;
      ptick_reg <= pdiv_wrap;
    end
  end

  assign machine_tick_o = mtick_reg;
  assign periph_tick_o = ptick_reg;

  ////////////////////////////////////////////////////////////////////////////
  // reset sources and stabilisation delay

  logic pin_meta_reg;
  logic pin_sync_reg;
  ctr_state_t state_reg;
  ctr_state_t state_next;
  logic [`CTR_STAB_W-1:0] stab_reg;
  logic [2:0] cause_reg;
  logic wdg_seen_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // idle level of the pin, so no false reset cause follows rst_i
      pin_meta_reg <= 1'b1;
      pin_sync_reg <= 1'b1;
    end else begin
      pin_meta_reg <= reset_n_i;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  wire pin_low = ~pin_sync_reg;
  // a timeout is caught once and then held by the reset sequence itself
  wire wdg_event = wdg_timeout_i & ~wdg_seen_reg;
  wire any_source = pin_low | por_i | wdg_event;
  wire stab_done = (stab_reg == `CTR_STAB_W'(`CTR_STAB_CYCLES - 1));

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      CTR_ST_HOLD: begin
        if (!pin_low && !por_i) begin
          state_next = CTR_ST_WAIT_OSC;
        end
      end
      CTR_ST_WAIT_OSC: begin
        if (osc_ready_i) begin
          state_next = CTR_ST_STAB;
        end
      end
      CTR_ST_STAB: begin
        if (stab_done) begin
          state_next = CTR_ST_RUN;
        end
      end
      CTR_ST_RUN: begin
        state_next = CTR_ST_RUN;
      end
      default: begin
        state_next = CTR_ST_HOLD;
      end
    endcase
    if (any_source) begin
      state_next = CTR_ST_HOLD;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= CTR_ST_HOLD;
      stab_reg <= '0;
      wdg_seen_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      stab_reg <= (state_reg == CTR_ST_STAB) ? stab_reg + `CTR_STAB_W'(1) : '0;
      if (state_reg == CTR_ST_RUN) begin
        wdg_seen_reg <= 1'b0;
      end else if (wdg_event) begin
        wdg_seen_reg <= 1'b1;
      end
    end
  end

  logic ack_reg;
  wire [7:0] wb_idx = wb_req_i.adr;
  wire wb_hit = wb_req_i.cyc & wb_req_i.stb & ~ack_reg;
  wire wb_wr = wb_hit & wb_req_i.we & wb_req_i.sel[0];

  // cause bits are sticky across internal reset; a source wins over a clear
  wire cause_clr = wb_wr && (wb_idx == `CTR_IDX_RST_STAT);
  wire [2:0] cause_set = {wdg_event, por_i, pin_low};
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cause_reg <= 3'h0;
    end else begin
      cause_reg <= (cause_clr ? (cause_reg & ~wb_req_i.dat[2:0]) : cause_reg) | cause_set;
    end
  end

  wire in_reset = (state_reg != CTR_ST_RUN);
  assign internal_reset_o = in_reset;
  assign io_pullup_o = in_reset;
  // the main oscillator is kicked again on every fresh reset, also in stop
  assign main_osc_restart_o = (state_reg == CTR_ST_HOLD);
  assign wdg_reload_o = (state_reg == CTR_ST_HOLD);

  ////////////////////////////////////////////////////////////////////////////
  // register bus

  logic [31:0] rdat_reg;
  logic [7:0] osc_reg;
  logic [1:0] cpu_reg;
  ctr_ctx_t ctx_reg;

  // the register lags reset by a cycle; the view is nmi at once
  wire ctr_ctx_t ctx_view = in_reset ? CTR_CTX_NMI : ctx_reg;
  wire [1:0] pend_view = {cpu_reg[1], 1'b0};
  wire [7:0] osc_view = osc_reg;
  wire [31:0] rd_mux =
    (wb_idx == `CTR_IDX_OSC_CTRL) ? {24'h000000, osc_view} :
    (wb_idx == `CTR_IDX_RST_STAT) ? {29'h00000000, cause_reg} :
    (wb_idx == `CTR_IDX_CPU_CTRL) ? {28'h0000000, ctx_view, pend_view} :
    32'h00000000;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      rdat_reg <= 32'h00000000;
    end else begin
      ack_reg <= wb_hit;
      rdat_reg <= wb_hit ? rd_mux : rdat_reg;
    end
  end

  assign wb_rsp_o.ack = ack_reg;
  assign wb_rsp_o.dat = rdat_reg;

  ////////////////////////////////////////////////////////////////////////////
  // standby oscillator and timebase chain

  logic [`CTR_CHAIN_W-1:0] chain_reg;
  wire osc_run = osc_reg[`CTR_BIT_OSC_RUN];
  wire chain_tick = osc_run ? standby_tick_i : mtick_reg;
  wire chain_wrap = chain_tick && (chain_reg == `CTR_CHAIN_LAST);
  wire osc_wr = wb_wr && (wb_idx == `CTR_IDX_OSC_CTRL);
  logic [7:0] osc_next;

  always_comb begin
    osc_next = osc_wr ? wb_req_i.dat[7:0] : osc_reg;
    osc_next[4:0] = osc_wr ? wb_req_i.dat[4:0] : osc_reg[4:0];
    if (chain_wrap) begin
      osc_next[`CTR_BIT_ELAPSED] = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || in_reset) begin
      osc_reg <= `CTR_OSC_RESET;
      chain_reg <= '0;
    end else begin
      osc_reg <= osc_next;
      chain_reg <= chain_tick ? chain_reg + `CTR_CHAIN_W'(1) : chain_reg;
    end
  end

  assign timebase_irq_o = osc_reg[`CTR_BIT_IRQ_EN] & osc_reg[`CTR_BIT_ELAPSED];
  assign standby_osc_en_o = osc_run;
  assign display_clk_en_o = osc_run;

  ////////////////////////////////////////////////////////////////////////////
  // machine cycle sequencing of instructions

  logic [`CTR_PHASE_W-1:0] phase_reg;
  wire [`CTR_PHASE_W-1:0] phase_last =
    (ilen_i == CTR_LEN_2) ? `CTR_PHASE_LAST_2 :
    (ilen_i == CTR_LEN_4) ? `CTR_PHASE_LAST_4 : `CTR_PHASE_LAST_5;
  wire phase_end = mtick_reg && (phase_reg == phase_last);

  always_ff @(posedge clk_i) begin
    if (rst_i || in_reset) begin
      phase_reg <= '0;
    end else if (mtick_reg) begin
      phase_reg <= phase_end ? '0 : phase_reg + `CTR_PHASE_W'(1);
    end
  end

  assign instr_done_o = phase_end && !in_reset;

  ////////////////////////////////////////////////////////////////////////////
  // cpu start context

  logic in_reset_d_reg;
  logic serve_reg;
  wire cpu_wr = wb_wr && (wb_idx == `CTR_IDX_CPU_CTRL);
  // retire from the bus or the core both count as a return-from-interrupt
  wire return_from_interrupt = retire_i | (cpu_wr & wb_req_i.dat[`CTR_BIT_RETURN_FROM_INTERRUPT]);

  always_ff @(posedge clk_i) begin
    if (rst_i || in_reset) begin
      ctx_reg <= CTR_CTX_NMI;
      cpu_reg <= 2'b00;
      serve_reg <= 1'b0;
    end else begin
      if (cpu_wr) begin
        cpu_reg[1] <= wb_req_i.dat[`CTR_BIT_IRQ_PEND];
      end
      serve_reg <= 1'b0;
      if (return_from_interrupt && ctx_reg == CTR_CTX_NMI) begin
        // pending work is served, otherwise fall through in sequence
        ctx_reg <= (cpu_reg[1] | timebase_irq_o) ? CTR_CTX_IRQ : CTR_CTX_NORMAL;
        serve_reg <= cpu_reg[1] | timebase_irq_o;
      end else if (return_from_interrupt) begin
        ctx_reg <= CTR_CTX_NORMAL;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      in_reset_d_reg <= 1'b1;
    end else begin
      in_reset_d_reg <= in_reset;
    end
  end

  assign cpu_ctl_o.core_reset = in_reset;
  assign cpu_ctl_o.stack_clear = in_reset;
  assign cpu_ctl_o.pc_load = `CTR_RESET_VECTOR;
  assign cpu_ctl_o.pc_load_en = in_reset_d_reg & ~in_reset;
  assign cpu_ctl_o.ctx = ctx_view;
  assign cpu_ctl_o.service_pending = serve_reg;

endmodule // ctr_clock_reset

// File: tb/ctr_chk.sv
`timescale 1ns/100ps
module ctr_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire ctr_pkg::ctr_wb_req_t wb_req_i,
  input wire ctr_pkg::ctr_wb_rsp_t wb_rsp_o,
  input wire logic reset_n_i,
  input wire logic por_i,
  input wire logic wdg_timeout_i,
  input wire logic osc_ready_i,
  input wire logic machine_tick_o,
  input wire logic periph_tick_o,
  input wire logic standby_osc_en_o,
  input wire logic display_clk_en_o,
  input wire logic internal_reset_o,
  input wire logic io_pullup_o,
  input wire logic wdg_reload_o,
  input wire ctr_pkg::ctr_cpu_ctl_t cpu_ctl_o
);
  import ctr_pkg::*;
  int hi_cnt;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // cycles held in reset with every cause gone; a pin or por cause restarts it, a watchdog timeout does not
  always_ff @(posedge clk_i) begin
    if (!internal_reset_o || !reset_n_i || !osc_ready_i || por_i) hi_cnt <= 0;
    else hi_cnt <= hi_cnt + 1;
  end
  mach_period_a: assert property (machine_tick_o |=> !machine_tick_o [*8] ##1 !machine_tick_o [*4] ##1 machine_tick_o)
    else $error("machine tick period wrong");
  periph_period_a: assert property (periph_tick_o |=> !periph_tick_o [*8] ##1 !periph_tick_o [*3] ##1 periph_tick_o)
    else $error("periph tick period wrong");
  disp_follow_a: assert property (display_clk_en_o == standby_osc_en_o)
    else $error("display clock enable differs");
  pulse_ext_a: assert property ($fell(reset_n_i) |-> ##[1:4] internal_reset_o)
    else $error("pin pulse gave no reset");
  pullup_a: assert property (io_pullup_o == internal_reset_o)
    else $error("pull-up not tied to reset");
  stab_min_a: assert property ($fell(internal_reset_o) |-> hi_cnt >= 2048)
    else $error("reset released early");
  stab_max_a: assert property (internal_reset_o |-> hi_cnt < 2060)
    else $error("reset held too long");
  vector_load_a: assert property ($fell(internal_reset_o) |-> ##[0:1] (cpu_ctl_o.pc_load_en && cpu_ctl_o.pc_load == 12'hFFE))
    else $error("reset vector not loaded");
  nmi_start_a: assert property (internal_reset_o |-> cpu_ctl_o.ctx == CTR_CTX_NMI)
    else $error("context not nmi in reset");
  wdg_reset_a: assert property (wdg_timeout_i && !internal_reset_o |-> ##[1:4] (internal_reset_o && wdg_reload_o))
    else $error("watchdog reset missing");
  ack_once_a: assert property (wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack |=> wb_rsp_o.ack ##1 !wb_rsp_o.ack)
    else $error("bus ack wrong");
  cover property ($fell(internal_reset_o));
  cover property (wdg_timeout_i ##1 internal_reset_o);
  cover property (wb_rsp_o.ack && wb_req_i.we);
endmodule // ctr_chk
bind ctr_clock_reset ctr_chk i_chk (.clk_i, .rst_i, .wb_req_i, .wb_rsp_o, .reset_n_i, .por_i, .wdg_timeout_i,
  .osc_ready_i, .machine_tick_o, .periph_tick_o, .standby_osc_en_o, .display_clk_en_o, .internal_reset_o,
  .io_pullup_o, .wdg_reload_o, .cpu_ctl_o);

// File: tb/ctr_partner.sv
`timescale 1ns/100ps
module ctr_partner (
  input wire logic clk_i,
  input wire logic osc_en_i,
  input wire logic pulse_i,
  output logic reset_n_o,
  output logic osc_ready_o,
  output logic tick_o
);
  int n = 0;
  initial begin
    reset_n_o = 1'b1;
    osc_ready_o = 1'b0;
    tick_o = 1'b0;
  end
  // the main oscillator only counts as running a while after power-up
  always @(posedge clk_i) begin
    n <= n + 1;
    osc_ready_o <= (n > 40);
    reset_n_o <= !pulse_i;
    tick_o <= osc_en_i && (n % 305 == 0);
  end
endmodule // ctr_partner

// File: tb/testbench.sv
`timescale 1ns/100ps
module testbench;
  import ctr_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic por_i = 1'b1;
  logic wdg_timeout_i = 1'b0;
  logic pin_pulse = 1'b0;
  ctr_ilen_t ilen_i = CTR_LEN_2;
  ctr_wb_req_t wb_req_i = '0;
  ctr_wb_rsp_t wb_rsp_o;
  logic reset_n_i, osc_ready_i, standby_tick_i, machine_tick_o, instr_done_o;
  logic timebase_irq_o, standby_osc_en_o, internal_reset_o;
  int bad_count = 0;
  int cmp_count = 0;
  int cyc_n = 0;
  int m_osc = 0;
  always #50 clk_i = ~clk_i;
  ctr_partner i_far (.clk_i, .osc_en_i(standby_osc_en_o), .pulse_i(pin_pulse), .reset_n_o(reset_n_i),
    .osc_ready_o(osc_ready_i), .tick_o(standby_tick_i));
  ctr_clock_reset i_dut (.clk_i, .rst_i, .wb_req_i, .wb_rsp_o, .reset_n_i, .por_i, .wdg_timeout_i, .osc_ready_i,
    .stop_mode_i(1'b0), .standby_tick_i, .retire_i(1'b0), .ilen_i, .machine_tick_o, .periph_tick_o(),
    .instr_done_o, .timebase_irq_o, .standby_osc_en_o, .display_clk_en_o(), .internal_reset_o,
    .io_pullup_o(), .main_osc_restart_o(), .wdg_reload_o(), .cpu_ctl_o());
  ////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("cmp_count=%0d bad_count=%0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic cmp_n(input string n, input int e, input int g);
    cmp_count++;
    if (g != e) begin
      bad_count++;
      $display("unexpected %s exp %0d got %0d", n, e, g);
    end
  endtask
  // the request stands until ack is sampled, then the bus idles a cycle
  task automatic bus(input logic we, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
    output logic [7:0] q);
    wb_req_i <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: s, dat: {24'h0, d}};
    do begin
      @(posedge clk_i);
    end while (wb_rsp_o.ack !== 1'b1);
    q = wb_rsp_o.dat[7:0];
    wb_req_i <= '0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
    logic [7:0] q;
    bus(1'b1, a, d, s, q);
    if (a == 8'hDB && s[0]) m_osc = d;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, 4'hF, q);
    cmp($sformatf("reg %h", a), e, q);
  endtask
  // fixed window: the release must land inside it
  task automatic stab();
    int c;
    c = 0;
    repeat (2300) begin
      @(posedge clk_i);
      if (internal_reset_o === 1'b1 && reset_n_i && osc_ready_i && !por_i) c++;
    end
    m_osc = 0;
    cmp_n("stab window", 1, int'(c >= 2048 && c <= 2060));
    cmp("internal reset", 8'h00, {7'h0, internal_reset_o});
  endtask
  task automatic ticks(output int c);
    c = 0;
    repeat (100) begin
      @(posedge clk_i);
      if (machine_tick_o === 1'b1) c++;
      if (instr_done_o === 1'b1) break;
    end
  endtask
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      bad_count++;
      end_sim();
    end
  end
  initial begin
    int c;
    logic [7:0] d;
    ctr_ilen_t codes[3];
    int lens[3];
    codes = '{CTR_LEN_2, CTR_LEN_4, CTR_LEN_5};
    lens = '{2, 4, 5};
    void'($urandom(32'hB43359EA));
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    por_i <= 1'b0;
    stab();
    rd(8'hDC, 8'h02);
    wr(8'hDC, 8'h07, 4'hF);
    rd(8'hDD, 8'h08);
    wr(8'hDD, 8'h01, 4'hF);
    rd(8'hDD, 8'h00);
    repeat (6) begin
      d = 8'($urandom);
      wr(8'hDB, d, 4'hF);
      rd(8'hDB, m_osc[7:0]);
      cmp("osc enable", {7'h0, m_osc[5]}, {7'h0, standby_osc_en_o});
      cmp("timebase irq", {7'h0, m_osc[7] & m_osc[6]}, {7'h0, timebase_irq_o});
    end
    wr(8'hDB, 8'hBF, 4'h0);
    rd(8'hDB, m_osc[7:0]);
    rd(8'h10, 8'h00);
    for (int i = 0; i < 3; i++) begin
      ilen_i <= codes[i];
      ticks(c);
      ticks(c);
      ticks(c);
      cmp_n("instr ticks", lens[i], c);
    end
    for (int k = 0; k < 2; k++) begin
      wr(8'hDB, 8'hA5, 4'hF);
      if (k == 0) pin_pulse <= 1'b1;
      else wdg_timeout_i <= 1'b1;
      @(posedge clk_i);
      pin_pulse <= 1'b0;
      wdg_timeout_i <= 1'b0;
      stab();
      rd(8'hDB, m_osc[7:0]);
      rd(8'hDC, (k == 0) ? 8'h01 : 8'h04);
      wr(8'hDC, 8'h07, 4'hF);
    end
    end_sim();
  end
endmodule // testbench
